// ===== conveyor_speed_follow_encoder.sv
// Notes on behaviour
// [RULE1] feed rate follows measured belt speed
// [RULE2] belt stop halts feed, restart resumes
// [RULE3] pneumatic edge forbids speed following
// [RULE4] single-phase counts channel A only
// [RULE5] single-phase: every A pulse is movement
// [RULE6] quadrature decode: direction, double resolution
// [RULE7] quadrature keeps direction, jitter nets zero
// [RULE8] inverted mode flips channel B first
// [RULE9] resolution setting 0.0 to 9999
// [RULE10] speed from rate, resolution, diameter
// [RULE11] diameter edit shows speed and variable flag
// [RULE12] synchronise and filter encoder inputs
`include "speed_follow_map.svh"
`timescale 1ns/1ps
`default_nettype none

module conveyor_speed_follow_encoder #(
  parameter int GATE_CYCLES = `GATE_CYCLES,
  parameter int FILT_CYCLES = `FILT_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic pneumatic_edge,
  input wire logic label_feed_req,
  output logic [15:0] feed_rate,
  output logic feed_run,
  output logic follow_active,
  output logic belt_moving
);

  // gate timer width
  localparam int GW = $clog2(GATE_CYCLES + 1);
  // dividend and divisor widths
  localparam int NW = 48;
  localparam int DW = 26;
  // measuring windows per second
  localparam int GATES_PER_S = `CLK_FREQ_HZ / GATE_CYCLES;
  // scale to 0.1 mm/s with pi in q8
  localparam logic [NW-1:0] NUM_K = NW'(`PI_Q8 * 10 * GATES_PER_S);
  // window count limits, symmetric
  localparam logic signed [15:0] CNT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] CNT_MIN = -16'sh7FFF;

  // whole block state
  typedef struct packed {
    logic pn_s1; // pneumatic strap, first stage
    logic pn_s2; // pneumatic strap, second stage
    logic follow_en; // software enable
    logic [1:0] mode; // encoder counting mode
    logic diam_edit; // diameter being edited
    logic [16:0] resol; // pulses per turn, tenths
    logic [10:0] diam; // wheel diameter, tenths mm
    logic [GW-1:0] gate_cnt; // measuring window timer
    logic signed [15:0] win_cnt; // net counts this window
    logic [31:0] pos; // signed travel in counts
    logic moving; // belt movement seen
    logic dir_rev; // last step was reverse
    logic div_start; // launch speed division
    logic [NW-1:0] num; // division dividend
    logic [DW-1:0] den; // division divisor
    logic [15:0] speed; // belt speed, 0.1 mm/s
    logic var_flag; // speed changed at last update
    logic [15:0] feed_rate; // label feed setpoint
    logic feed_run; // label feed running
    logic active; // speed following in force
    logic [31:0] rdata; // read data
  } top_state_t;

  top_state_t q, d;

  // decoder outputs
  logic step;
  logic step_rev;
  // divider outputs
  logic div_done;
  logic [NW-1:0] div_quot;
  // combinational helpers
  logic quad;
  logic [15:0] mag;
  logic [NW-1:0] den_full;

  // encoder synchroniser, filter and decoder
  enc_decode #(
    .FILT(FILT_CYCLES)
  ) u_dec (
    .mclk(mclk),
    .nrst(nrst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .mode(q.mode),
    .step(step),
    .step_rev(step_rev)
  );

  // speed division
  // dividend and divisor held in state until done
  seq_divider #(
    .NW(NW),
    .DW(DW)
  ) u_div (
    .mclk(mclk),
    .nrst(nrst),
    .start(q.div_start),
    .num(q.num),
    .den(q.den),
    .done(div_done),
    .quot(div_quot)
  );

  // next-state logic
  always_comb begin
    d = q;
    // strobes and read data default low
    d.div_start = 1'b0;
    d.rdata = 32'h00000000;
    // mode decode used by counting and scaling
    quad = (q.mode == speed_follow_pkg::ENC_QUAD) || (q.mode == speed_follow_pkg::ENC_QUAD_INV);
    mag = 16'h0000;
    den_full = '0;

    // pneumatic strap from a pin
    d.pn_s1 = pneumatic_edge;
    d.pn_s2 = q.pn_s1;

    // register writes
    if (reg_wr) begin
      if (reg_addr == `CTRL_OFS) begin
        // enable, mode and edit flag
        d.follow_en = reg_wdata[`CTRL_FOLLOW_BIT];
        d.mode = reg_wdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
        d.diam_edit = reg_wdata[`CTRL_EDIT_BIT];
      end else if (reg_addr == `RESOL_OFS) begin
        // [RULE9] clamp resolution range
        if (reg_wdata > 32'(`RESOL_MAX)) begin
          d.resol = `RESOL_MAX;
        end else begin
          d.resol = reg_wdata[16:0];
        end
      end else if (reg_addr == `DIAM_OFS) begin
        // [RULE10] clamp diameter range
        if (reg_wdata > 32'(`DIAM_MAX)) begin
          d.diam = `DIAM_MAX;
        end else begin
          d.diam = reg_wdata[10:0];
        end
      end
    end

    // count steps within the window
    if (step) begin
      if (quad) begin
        // [RULE7] signed net count, jitter cancels
        d.dir_rev = step_rev;
        if (step_rev) begin
          // reverse step
          d.pos = q.pos - 32'h00000001;
          if (q.win_cnt != CNT_MIN) begin
            d.win_cnt = q.win_cnt - 16'sh0001;
          end
        end else begin
          // forward step
          d.pos = q.pos + 32'h00000001;
          if (q.win_cnt != CNT_MAX) begin
            d.win_cnt = q.win_cnt + 16'sh0001;
          end
        end
      end else begin
        // [RULE5] every pulse is forward movement
        // no direction information in this mode
        d.dir_rev = 1'b0;
        d.moving = 1'b1;
        d.pos = q.pos + 32'h00000001;
        if (q.win_cnt != CNT_MAX) begin
          d.win_cnt = q.win_cnt + 16'sh0001;
        end
      end
    end

    // window end: judge movement, launch speed
    if (q.gate_cnt == GW'(GATE_CYCLES - 1)) begin
      // restart the window timer
      d.gate_cnt = '0;
      // a step on the boundary cycle opens the next window
      d.win_cnt = d.win_cnt - q.win_cnt;
      // forward magnitude only, reverse travel reads as zero
      if (q.win_cnt > 16'sh0000) begin
        mag = q.win_cnt;
      end
      // [RULE2] no travel in window means stopped
      d.moving = (mag != 16'h0000) || (step && !quad);
      // [RULE10] den = resolution x mult x 256
      // quad counts both a edges, so the divisor doubles
      if (quad) begin
        den_full = NW'({q.resol, 1'b0, 8'h00});
      end else begin
        den_full = NW'({q.resol, 8'h00});
      end
      // dividend = count x diameter x scale
      d.num = NW'(NW'(mag) * NW'(q.diam) * NUM_K);
      d.den = den_full[DW-1:0];
      if (q.resol == 17'h00000) begin
        // no resolution, no speed
        d.var_flag = (q.speed != 16'h0000);
        d.speed = 16'h0000;
      end else begin
        d.div_start = 1'b1;
      end
    end else begin
      // window still open
      d.gate_cnt = q.gate_cnt + GW'(1);
    end

    // speed update from divider, saturated
    if (div_done) begin
      // clamp to the 16-bit speed range
      if (div_quot > NW'(16'hFFFF)) begin
        d.speed = 16'hFFFF;
      end else begin
        d.speed = div_quot[15:0];
      end
      // flag a changed speed for calibration
      d.var_flag = (d.speed != q.speed);
    end

    // [RULE3] pneumatic edge blocks following
    // strap is read only after its second sync stage
    d.active = q.follow_en && !q.pn_s2;

    if (q.active) begin
      // [RULE1] feed rate tracks belt speed
      d.feed_rate = q.speed;
      // [RULE2] halt when stopped, resume on movement
      d.feed_run = label_feed_req && q.moving;
    end else begin
      // plain feeding without following
      d.feed_rate = 16'h0000;
      d.feed_run = label_feed_req;
    end

    // register reads, one cycle later
    if (reg_rd) begin
      if (reg_addr == `CTRL_OFS) begin
        // control word back
        d.rdata[`CTRL_FOLLOW_BIT] = q.follow_en;
        d.rdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB] = q.mode;
        d.rdata[`CTRL_EDIT_BIT] = q.diam_edit;
      end else if (reg_addr == `RESOL_OFS) begin
        // resolution setting
        d.rdata = 32'(q.resol);
      end else if (reg_addr == `DIAM_OFS) begin
        // diameter setting
        d.rdata = 32'(q.diam);
      end else if (reg_addr == `STATUS_OFS) begin
        // status flags
        d.rdata[`STAT_ACTIVE_BIT] = q.active;
        d.rdata[`STAT_MOVING_BIT] = q.moving;
        d.rdata[`STAT_REV_BIT] = q.dir_rev;
        // [RULE11] variable flag shown while editing
        d.rdata[`STAT_VAR_BIT] = q.var_flag && q.diam_edit;
        d.rdata[`STAT_PNEU_BIT] = q.pn_s2;
      end else if (reg_addr == `SPEED_OFS) begin
        // [RULE11] measured speed for calibration
        d.rdata = 32'(q.speed);
      end else if (reg_addr == `POS_OFS) begin
        // net travel, wraps
        d.rdata = q.pos;
      end else begin
        // unmapped address reads zero
        d.rdata = 32'h00000000;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // settings to their reset defaults
      q <= '0;
      q.resol <= `RESOL_RST;
      q.diam <= `DIAM_RST;
    end else begin
      // normal update
      q <= d;
    end
  end

  // outputs straight from flops
  assign reg_rdata = q.rdata;
  assign feed_rate = q.feed_rate;
  assign feed_run = q.feed_run;
  assign follow_active = q.active;
  assign belt_moving = q.moving;

endmodule

`default_nettype wire

// ===== speed_follow_map.svh
`ifndef SPEED_FOLLOW_MAP_SVH
`define SPEED_FOLLOW_MAP_SVH

// register byte offsets
`define CTRL_OFS 8'h00
`define RESOL_OFS 8'h04
`define DIAM_OFS 8'h08
`define STATUS_OFS 8'h0C
`define SPEED_OFS 8'h10
`define POS_OFS 8'h14

// control field positions
`define CTRL_FOLLOW_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_EDIT_BIT 3

// status field positions
`define STAT_ACTIVE_BIT 0
`define STAT_MOVING_BIT 1
`define STAT_REV_BIT 2
`define STAT_VAR_BIT 3
`define STAT_PNEU_BIT 4

// reset values and setting limits, tenths of a unit
`define RESOL_RST 17'h00000
`define DIAM_RST 11'h000
`define RESOL_MAX 17'h18696
`define DIAM_MAX 11'h7D0

// timing
`define CLK_FREQ_HZ 10000000
`define GATE_TIME_MS 100
`define GATE_CYCLES ((`GATE_TIME_MS * `CLK_FREQ_HZ) / 1000)
`define FILT_TIME_NS 500
`define FILT_CYCLES ((`FILT_TIME_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)

// pi scaled by 256
`define PI_Q8 804

`endif

// ===== speed_follow_pkg.sv
package speed_follow_pkg;

  // encoder counting modes
  typedef enum logic [1:0] {
    ENC_SINGLE,
    ENC_QUAD,
    ENC_QUAD_INV
  } enc_mode_t;

  // divider sequencer states
  typedef enum logic {
    DIV_IDLE,
    DIV_RUN
  } div_state_t;

endpackage

// ===== enc_decode.sv
`timescale 1ns/1ps
`default_nettype none

module enc_decode #(
  parameter int FILT = 5
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [1:0] mode,
  output logic step,
  output logic step_rev
);

  localparam int FW = $clog2(FILT + 1);

  // whole decoder state
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] filt;
    logic [1:0][FW-1:0] cnt;
    logic step;
    logic step_rev;
  } dec_state_t;

  dec_state_t q, d;
  logic b_eff; // channel b after optional inversion

  // synchroniser, filter and edge decode
  always_comb begin
    d = q;
    d.step = 1'b0;
    d.step_rev = 1'b0;
    // [RULE12] two-stage synchroniser
    d.s1 = {enc_b, enc_a};
    d.s2 = q.s1;
    // [RULE12] per-channel glitch filter
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.filt[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] == FW'(FILT - 1)) begin
        d.filt[i] = q.s2[i];
        d.cnt[i] = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + FW'(1);
      end
    end
    // [RULE8] invert channel b
    b_eff = (mode == speed_follow_pkg::ENC_QUAD_INV) ? ~q.filt[1] : q.filt[1];
    if (mode == speed_follow_pkg::ENC_QUAD || mode == speed_follow_pkg::ENC_QUAD_INV) begin
      // [RULE6] both a edges, direction from b
      if (d.filt[0] != q.filt[0]) begin
        d.step = 1'b1;
        d.step_rev = ~(d.filt[0] ^ b_eff);
      end
    end else begin
      // [RULE4] only rising a counts
      if (d.filt[0] && !q.filt[0]) begin
        d.step = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign step = q.step;
  assign step_rev = q.step_rev;

endmodule

`default_nettype wire

// ===== seq_divider.sv
`timescale 1ns/1ps
`default_nettype none

module seq_divider #(
  parameter int NW = 48,
  parameter int DW = 26
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic done,
  output logic [NW-1:0] quot
);

  localparam int CW = $clog2(NW + 1);

  // whole divider state
  typedef struct packed {
    speed_follow_pkg::div_state_t st;
    logic [DW-1:0] rem;
    logic [DW-1:0] den;
    logic [NW-1:0] sh;
    logic [CW-1:0] cnt;
    logic done;
  } div_t;

  div_t q, d;
  logic [DW:0] trial; // partial remainder with next bit

  // restoring division, one bit per cycle
  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = {q.rem, q.sh[NW-1]};
    case (q.st)
      speed_follow_pkg::DIV_IDLE: begin
        if (start) begin
          d.st = speed_follow_pkg::DIV_RUN;
          d.sh = num;
          d.den = den;
          d.rem = '0;
          d.cnt = CW'(NW);
        end
      end
      default: begin
        // subtract when it fits
        if (trial >= {1'b0, q.den}) begin
          d.rem = DW'(trial - {1'b0, q.den});
          d.sh = {q.sh[NW-2:0], 1'b1};
        end else begin
          d.rem = trial[DW-1:0];
          d.sh = {q.sh[NW-2:0], 1'b0};
        end
        d.cnt = q.cnt - CW'(1);
        if (q.cnt == CW'(1)) begin
          d.st = speed_follow_pkg::DIV_IDLE;
          d.done = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign quot = q.sh;

endmodule

`default_nettype wire

// ===== HANDOVER_END_MARKER_NOT_USED.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// belt encoder: one quadrature phase per step request
module enc_model (
  input wire logic mclk,
  input wire logic step,
  input wire logic rev,
  input wire logic glitch,
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q = 2'h0; // phase index
  // phase advance, backwards on rev
  always_ff @(posedge mclk) begin
    if (step) begin
      ph_q <= rev ? ph_q - 2'h1 : ph_q + 2'h1;
    end
  end
  // a leads b by a quarter
  assign enc_a = (ph_q[0] ^ ph_q[1]) ^ glitch;
  assign enc_b = ph_q[1];
endmodule
`default_nettype wire

// ===== follow_checks_properties.sv
`include "speed_follow_map.svh"
`timescale 1ns/1ps
`default_nettype none
// port checks of the follow block
module follow_checker #(
  parameter int GATE_CYCLES = 200,
  parameter int FILT_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic pneumatic_edge,
  input wire logic label_feed_req,
  input wire logic [15:0] feed_rate,
  input wire logic feed_run,
  input wire logic follow_active,
  input wire logic belt_moving
);
  localparam int QUIET = 2 * GATE_CYCLES + FILT_CYCLES + 16; // two windows plus latency
  logic [11:0] quiet_q; // cycles since a pin moved
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // quiet time counter, saturating
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 12'h000;
    end else if ($changed(enc_a) || $changed(enc_b)) begin
      quiet_q <= 12'h000;
    end else if (quiet_q != 12'hFFF) begin
      quiet_q <= quiet_q + 12'h001;
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) // idle
    else $error("read data without a read");
  resol_clamp_a: assert property (reg_rd && reg_addr == `RESOL_OFS |=> reg_rdata <= 32'h18696)
    else $error("resolution above limit");
  diam_clamp_a: assert property (reg_rd && reg_addr == `DIAM_OFS |=> reg_rdata <= 32'h7D0)
    else $error("diameter above limit");
  pneu_block_a: assert property (pneumatic_edge [*5] |-> !follow_active)
    else $error("following with pneumatic edge");
  pneu_rate_a: assert property (pneumatic_edge [*6] |-> feed_rate == 16'h0000)
    else $error("rate set with pneumatic edge");
  follow_off_a: assert property (reg_wr && reg_addr == `CTRL_OFS && !reg_wdata[0]
    |-> ##[1:3] !follow_active)
    else $error("following not switched off");
  stop_halt_a: assert property (follow_active && !belt_moving ##1 follow_active && !belt_moving
    |-> !feed_run)
    else $error("feed runs on a stopped belt");
  restart_a: assert property (follow_active && belt_moving && label_feed_req
    ##1 follow_active && belt_moving |-> feed_run)
    else $error("feed not resumed");
  no_request_a: assert property (!label_feed_req ##1 !label_feed_req |-> !feed_run)
    else $error("feed runs without request");
  stop_detect_a: assert property (quiet_q >= QUIET |-> !belt_moving)
    else $error("movement without pulses");
  cover property (belt_moving && feed_run && follow_active);
  cover property (pneumatic_edge && feed_run);
  cover property ($fell(belt_moving) && follow_active);
endmodule
`default_nettype wire

// ===== conveyor_speed_follow_encoder_tb.sv
`include "speed_follow_map.svh"
`timescale 1ns/1ps
`default_nettype none
// bench for the belt follow block
module conveyor_speed_follow_encoder_tb;
  localparam int GATE = 200; // short gate window
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} reg_row_t;
  typedef struct {logic [31:0] c; int n; logic r; logic alt; logic [31:0] e;} mv_row_t;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic step = 1'b0; // encoder advance
  logic rev = 1'b0; // encoder backwards
  logic glitch = 1'b0; // spike on a
  logic enc_a;
  logic enc_b;
  logic pneumatic_edge = 1'b0;
  logic label_feed_req = 1'b0;
  logic [15:0] feed_rate;
  logic feed_run;
  logic follow_active;
  logic belt_moving;
  logic [31:0] p0;
  logic [31:0] p1;
  int n_errors = 0;
  int cmp_count = 0;
  // write, read back, expected value
  reg_row_t regs [7] = '{'{8'h04, 32'h1388, 32'h1388}, '{8'h04, 32'hFFFFFFFF, 32'h18696},
    '{8'h08, 32'hFFFF, 32'h7D0}, '{8'h08, 32'hA, 32'hA}, '{8'h20, 32'hFF, 32'h0},
    '{8'h10, 32'hFF, 32'h0}, '{8'h00, 32'h1, 32'h1}};
  // mode, steps, backwards, jitter, count change
  mv_row_t mvs [6] = '{'{32'h1, 8, 0, 0, 32'h2}, '{32'h1, 8, 0, 1, 32'h4},
    '{32'h3, 8, 0, 0, 32'h4}, '{32'h3, 8, 0, 1, 32'h0}, '{32'h5, 8, 1, 0, 32'h4},
    '{32'h7, 8, 0, 0, 32'h2}};
  // 10 MHz clock
  always #50 mclk = ~mclk;
  conveyor_speed_follow_encoder #(.GATE_CYCLES(GATE), .FILT_CYCLES(2)) DUT (.mclk, .nrst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .enc_a, .enc_b, .pneumatic_edge,
    .label_feed_req, .feed_rate, .feed_run, .follow_active, .belt_moving);
  enc_model enc (.mclk, .step, .rev, .glitch, .enc_a, .enc_b);
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // n encoder steps, five cycles apart
  task mv(input int n, input logic r, input logic alt);
    for (int i = 0; i < n; i++) begin
      rev <= r ^ (alt & i[0]);
      step <= 1'b1;
      @(posedge mclk);
      step <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // speed for diameter 1.0 mm, resolution 9999.0
  function automatic logic [31:0] espd(input longint c, input longint m);
    longint v;
    v = c * 10 * `PI_Q8 * 10 * (`CLK_FREQ_HZ / GATE) / (99990 * m * 256);
    return (v > 65535) ? 32'hFFFF : 32'(v);
  endfunction
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rd(regs[i].a, p1);
      chk(p1, regs[i].e);
    end
    $display("end register table");
    foreach (mvs[i]) begin
      wr(8'h00, mvs[i].c);
      rd(8'h14, p0);
      mv(mvs[i].n, mvs[i].r, mvs[i].alt);
      repeat (10) @(posedge mclk);
      rd(8'h14, p1);
      chk(p1 - p0, mvs[i].e);
    end
    $display("end motion table");
    rd(8'h14, p0);
    glitch <= 1'b1;
    @(posedge mclk);
    glitch <= 1'b0;
    repeat (10) @(posedge mclk);
    rd(8'h14, p1);
    chk(p1 - p0, 32'h0);
    $display("end glitch");
    label_feed_req <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, k ? 32'hB : 32'h1);
      fork
        mv(200, 1'b0, 1'b0);
        begin
          repeat (700) @(posedge mclk);
          rd(8'h10, p1);
          chk(p1, espd(10 * (k + 1), k + 1));
          chk(feed_rate, espd(10, 1));
          chk({feed_run, belt_moving, follow_active}, 32'h7);
          rd(8'h0C, p1);
          chk(p1 & 32'hB, 32'h3);
        end
      join
    end
    repeat (3 * GATE) @(posedge mclk);
    chk({feed_run, belt_moving}, 32'h0);
    fork
      mv(120, 1'b0, 1'b0);
      begin
        repeat (400) @(posedge mclk);
        chk({feed_run, belt_moving}, 32'h3);
      end
    join
    $display("end follow and stop");
    wr(8'h00, 32'h2);
    repeat (3) @(posedge mclk);
    chk({feed_rate, follow_active, feed_run}, 32'h1);
    wr(8'h00, 32'h3);
    repeat (3) @(posedge mclk);
    chk(follow_active, 32'h1);
    $display("end follow off");
    pneumatic_edge <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({feed_rate, follow_active}, 32'h0);
    chk(feed_run, 32'h1);
    rd(8'h0C, p1);
    chk(p1 & 32'h11, 32'h10);
    $display("end pneumatic");
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({feed_rate, feed_run, follow_active, belt_moving}, 32'h0);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(8'h04, p1);
    chk(p1, 32'h0);
    rd(8'h00, p1);
    chk(p1, 32'h0);
    $display("end reset");
    conclude;
  end
endmodule
bind conveyor_speed_follow_encoder follow_checker #(.GATE_CYCLES(GATE_CYCLES),
  .FILT_CYCLES(FILT_CYCLES)) chk_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .enc_a, .enc_b, .pneumatic_edge, .label_feed_req, .feed_rate, .feed_run,
  .follow_active, .belt_moving);
`default_nettype wire
